// ==== src/pprt_cfg.svh ====
// Address map, field positions and reset codes of the peripheral input pin router.
// Assumes nothing of its surroundings; included by the package and the design modules.
`ifndef PPRT_CFG_SVH
`define PPRT_CFG_SVH

`define PPRT_NUM_INPUTS   41
`define PPRT_CODE_W       6
`define PPRT_ADDR_W       12

// Byte offsets on the register bus
`define PPRT_SEL_BASE     12'h000
`define PPRT_PORT_BASE    12'h100
`define PPRT_ANALOG_BASE  12'h110
`define PPRT_BLOCK_SPAN   12'h010

// Pin code layout: port group in the top bits, pin number below
`define PPRT_GRP_MSB      5
`define PPRT_GRP_LSB      3
`define PPRT_PIN_MSB      2
`define PPRT_GRP_A        3'h0
`define PPRT_GRP_B        3'h1
`define PPRT_GRP_C        3'h2
`define PPRT_GRP_E        3'h4
`define PPRT_E3_BIT       3

// Permitted port masks, bit 0 port A, bit 1 port B, bit 2 port C
`define PPRT_ALLOW_AB     3'h3
`define PPRT_ALLOW_AC     3'h5
`define PPRT_ALLOW_BC     3'h6

// Reset values of the analog select bits
`define PPRT_ANALOG_RST   25'h0000000

// Power-on pin codes of the input select registers
`define PPRT_RST_EXT_INT      6'h08
`define PPRT_RST_TMR0_CLK     6'h04
`define PPRT_RST_TMR1_CLK     6'h10
`define PPRT_RST_TMR1_GATE    6'h0d
`define PPRT_RST_TMR2_IN      6'h13
`define PPRT_RST_TMR3_CLK     6'h10
`define PPRT_RST_TMR3_GATE    6'h10
`define PPRT_RST_TMR4_IN      6'h15
`define PPRT_RST_TMR5_CLK     6'h12
`define PPRT_RST_TMR5_GATE    6'h0c
`define PPRT_RST_TMR6_IN      6'h0f
`define PPRT_RST_MOD_CAR_LO   6'h01
`define PPRT_RST_MOD_CAR_HI   6'h04
`define PPRT_RST_MOD_SRC      6'h05
`define PPRT_RST_CAPTURE1     6'h12
`define PPRT_RST_CAPTURE2     6'h11
`define PPRT_RST_CAPTURE3     6'h0d
`define PPRT_RST_CAPTURE4     6'h08
`define PPRT_RST_CAPTURE5     6'h04
`define PPRT_RST_WAVE1_IN     6'h08
`define PPRT_RST_WAVE2_IN     6'h09
`define PPRT_RST_WAVE3_IN     6'h08
`define PPRT_RST_LOGIC_IN0    6'h00
`define PPRT_RST_LOGIC_IN1    6'h01
`define PPRT_RST_LOGIC_IN2    6'h0e
`define PPRT_RST_LOGIC_IN3    6'h0f
`define PPRT_RST_ADC_TRIG     6'h0c
`define PPRT_RST_SER1_CLK     6'h13
`define PPRT_RST_SER1_DATA    6'h14
`define PPRT_RST_SER1_SEL     6'h05
`define PPRT_RST_SER2_CLK     6'h09
`define PPRT_RST_SER2_DATA    6'h08
`define PPRT_RST_SER2_SEL     6'h08
`define PPRT_RST_UART1_RX     6'h17
`define PPRT_RST_UART1_CK     6'h16
`define PPRT_RST_UART2_RX     6'h0f
`define PPRT_RST_UART2_CK     6'h0e
`define PPRT_RST_MEAS1_SIG    6'h11
`define PPRT_RST_MEAS1_WIN    6'h10
`define PPRT_RST_MEAS2_SIG    6'h0d
`define PPRT_RST_MEAS2_WIN    6'h0c

`endif

// ==== src/pprt_pkg.sv ====
// Types shared by the peripheral input pin router modules.
// Assumes the configuration header is on the include path.
`include "pprt_cfg.svh"

package pprt_pkg;

  typedef logic [`PPRT_CODE_W-1:0] pprt_code_t;

  // Port pin levels, also used for the analog select bits
  typedef struct packed {
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [7:0] port_c;
    logic       port_e3;
  } pprt_pins_t;

  typedef logic [`PPRT_NUM_INPUTS-1:0] pprt_periph_t;

  typedef enum logic [1:0] {
    PPRT_ACC_NONE,
    PPRT_ACC_SEL,
    PPRT_ACC_PORT,
    PPRT_ACC_ANALOG
  } pprt_acc_kind_t;

  typedef struct packed {
    pprt_acc_kind_t kind;
    logic [5:0]     idx;
  } pprt_decode_t;

endpackage

// ==== src/pprt_input_mux.sv ====
// One peripheral input: picks a pin by its code and registers the level.
// Assumes pin levels are already synchronised to mclk.
`timescale 1ns/10ps
`default_nettype none
`include "pprt_cfg.svh"

module pprt_input_mux (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire pprt_pkg::pprt_code_t sel_code,
  input  wire logic [2:0]           allow,
  input  wire pprt_pkg::pprt_pins_t pins,
  output logic                      route_out
);

  logic [2:0] pin_idx;

  assign pin_idx = sel_code[`PPRT_PIN_MSB:0];

  // Same decode for every input, only the permitted mask differs
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      route_out <= 1'b0;
    end
    else
    begin
      case (sel_code[`PPRT_GRP_MSB:`PPRT_GRP_LSB])
        `PPRT_GRP_A: route_out <= allow[0] & pins.port_a[pin_idx];
        `PPRT_GRP_B: route_out <= allow[1] & pins.port_b[pin_idx];
        `PPRT_GRP_C: route_out <= allow[2] & pins.port_c[pin_idx];
        // No input may take port E, and unused codes fall here too
        default:     route_out <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== src/pprt_router.sv ====
// Peripheral input pin router: input select registers, pin synchronisers,
// port and analog select registers on APB, one routing mux per input.
// Assumes pins are asynchronous to mclk and peripherals run on mclk.
`timescale 1ns/10ps
`default_nettype none
`include "pprt_cfg.svh"

module pprt_router (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`PPRT_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire pprt_pkg::pprt_pins_t    pins_in,
  output var  pprt_pkg::pprt_periph_t   periph_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Lookup functions

  function automatic logic [2:0] pprt_allowed(input int unsigned i);
    case (i)
      0, 1:                                  pprt_allowed = `PPRT_ALLOW_AB;
      2, 4, 6, 8, 11, 12, 13, 18, 22, 23, 29: pprt_allowed = `PPRT_ALLOW_AC;
      default:                               pprt_allowed = `PPRT_ALLOW_BC;
    endcase
  endfunction

  function automatic pprt_pkg::pprt_code_t pprt_reset_code(input int unsigned i);
    case (i)
      0:       pprt_reset_code = `PPRT_RST_EXT_INT;
      1:       pprt_reset_code = `PPRT_RST_TMR0_CLK;
      2:       pprt_reset_code = `PPRT_RST_TMR1_CLK;
      3:       pprt_reset_code = `PPRT_RST_TMR1_GATE;
      4:       pprt_reset_code = `PPRT_RST_TMR2_IN;
      5:       pprt_reset_code = `PPRT_RST_TMR3_CLK;
      6:       pprt_reset_code = `PPRT_RST_TMR3_GATE;
      7:       pprt_reset_code = `PPRT_RST_TMR4_IN;
      8:       pprt_reset_code = `PPRT_RST_TMR5_CLK;
      9:       pprt_reset_code = `PPRT_RST_TMR5_GATE;
      10:      pprt_reset_code = `PPRT_RST_TMR6_IN;
      11:      pprt_reset_code = `PPRT_RST_MOD_CAR_LO;
      12:      pprt_reset_code = `PPRT_RST_MOD_CAR_HI;
      13:      pprt_reset_code = `PPRT_RST_MOD_SRC;
      14:      pprt_reset_code = `PPRT_RST_CAPTURE1;
      15:      pprt_reset_code = `PPRT_RST_CAPTURE2;
      16:      pprt_reset_code = `PPRT_RST_CAPTURE3;
      17:      pprt_reset_code = `PPRT_RST_CAPTURE4;
      18:      pprt_reset_code = `PPRT_RST_CAPTURE5;
      19:      pprt_reset_code = `PPRT_RST_WAVE1_IN;
      20:      pprt_reset_code = `PPRT_RST_WAVE2_IN;
      21:      pprt_reset_code = `PPRT_RST_WAVE3_IN;
      22:      pprt_reset_code = `PPRT_RST_LOGIC_IN0;
      23:      pprt_reset_code = `PPRT_RST_LOGIC_IN1;
      24:      pprt_reset_code = `PPRT_RST_LOGIC_IN2;
      25:      pprt_reset_code = `PPRT_RST_LOGIC_IN3;
      26:      pprt_reset_code = `PPRT_RST_ADC_TRIG;
      27:      pprt_reset_code = `PPRT_RST_SER1_CLK;
      28:      pprt_reset_code = `PPRT_RST_SER1_DATA;
      29:      pprt_reset_code = `PPRT_RST_SER1_SEL;
      30:      pprt_reset_code = `PPRT_RST_SER2_CLK;
      31:      pprt_reset_code = `PPRT_RST_SER2_DATA;
      32:      pprt_reset_code = `PPRT_RST_SER2_SEL;
      33:      pprt_reset_code = `PPRT_RST_UART1_RX;
      34:      pprt_reset_code = `PPRT_RST_UART1_CK;
      35:      pprt_reset_code = `PPRT_RST_UART2_RX;
      36:      pprt_reset_code = `PPRT_RST_UART2_CK;
      37:      pprt_reset_code = `PPRT_RST_MEAS1_SIG;
      38:      pprt_reset_code = `PPRT_RST_MEAS1_WIN;
      39:      pprt_reset_code = `PPRT_RST_MEAS2_SIG;
      40:      pprt_reset_code = `PPRT_RST_MEAS2_WIN;
      default: pprt_reset_code = 6'h00;
    endcase
  endfunction

  // Used by both the read and the write path
  function automatic pprt_pkg::pprt_decode_t pprt_decode(input logic [`PPRT_ADDR_W-1:0] addr);
    pprt_pkg::pprt_decode_t d;
    d.kind = pprt_pkg::PPRT_ACC_NONE;
    d.idx  = addr[7:2];
    if (addr[1:0] != 2'h0)
    begin
      d.kind = pprt_pkg::PPRT_ACC_NONE;
    end
    else if (addr < `PPRT_SEL_BASE + 12'(4 * `PPRT_NUM_INPUTS))
    begin
      d.kind = pprt_pkg::PPRT_ACC_SEL;
    end
    else if (addr >= `PPRT_PORT_BASE && addr < `PPRT_PORT_BASE + `PPRT_BLOCK_SPAN)
    begin
      d.kind = pprt_pkg::PPRT_ACC_PORT;
      d.idx  = {4'h0, addr[3:2]};
    end
    else if (addr >= `PPRT_ANALOG_BASE && addr < `PPRT_ANALOG_BASE + `PPRT_BLOCK_SPAN)
    begin
      d.kind = pprt_pkg::PPRT_ACC_ANALOG;
      d.idx  = {4'h0, addr[3:2]};
    end
    pprt_decode = d;
  endfunction

  // Narrow port view placed in the low bits of a bus word
  function automatic logic [31:0] pprt_port_word(input pprt_pkg::pprt_pins_t p,
                                                 input logic [1:0]           grp);
    case (grp)
      2'h0:    pprt_port_word = {24'h000000, p.port_a};
      2'h1:    pprt_port_word = {24'h000000, p.port_b};
      2'h2:    pprt_port_word = {24'h000000, p.port_c};
      default: pprt_port_word = {28'h0000000, p.port_e3, 3'h0};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  pprt_pkg::pprt_decode_t dec;
  pprt_pkg::pprt_code_t   sel_reg [0:`PPRT_NUM_INPUTS-1];
  pprt_pkg::pprt_pins_t   analog_sel_reg;
  pprt_pkg::pprt_pins_t   sync1_reg;
  pprt_pkg::pprt_pins_t   sync2_reg;
  pprt_pkg::pprt_pins_t   sync3_reg;
  pprt_pkg::pprt_pins_t   level_reg;
  pprt_pkg::pprt_pins_t   digital_in;
  logic                   setup_phase;
  logic                   wr_en;

  assign dec         = pprt_decode(paddr);
  assign setup_phase = psel & ~penable & ~pready;
  assign wr_en       = psel & penable & pready & pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Three stages; a level counts only once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_reg <= 25'h0000000;
      sync2_reg <= 25'h0000000;
      sync3_reg <= 25'h0000000;
    end
    else
    begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      level_reg <= 25'h0000000;
    end
    else
    begin
      level_reg <= (sync2_reg == sync3_reg) ? sync3_reg : level_reg;
    end
  end

  // Analog select turns the digital buffer off; the pin then reads low
  assign digital_in = level_reg & ~analog_sel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  generate
    for (genvar i = 0; i < `PPRT_NUM_INPUTS; i++)
    begin : g_input
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          sel_reg[i] <= pprt_reset_code(i);
        end
        else if (wr_en && dec.kind == pprt_pkg::PPRT_ACC_SEL && dec.idx == 6'(i))
        begin
          sel_reg[i] <= pwdata[`PPRT_CODE_W-1:0];
        end
      end

      // Every mux sees all pins, so sharing a pin costs nothing
      pprt_input_mux u_mux (
        .mclk      (mclk),
        .rst       (rst),
        .sel_code  (sel_reg[i]),
        .allow     (pprt_allowed(i)),
        .pins      (digital_in),
        .route_out (periph_in[i])
      );
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      analog_sel_reg <= `PPRT_ANALOG_RST;
    end
    else if (wr_en && dec.kind == pprt_pkg::PPRT_ACC_ANALOG)
    begin
      case (dec.idx[1:0])
        2'h0:    analog_sel_reg.port_a  <= pwdata[7:0];
        2'h1:    analog_sel_reg.port_b  <= pwdata[7:0];
        2'h2:    analog_sel_reg.port_c  <= pwdata[7:0];
        default: analog_sel_reg.port_e3 <= pwdata[`PPRT_E3_BIT];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  // One wait-free access cycle: ready is raised in the cycle after setup
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      // Error stands only in the access cycle, like ready
      pslverr <= setup_phase && (dec.kind == pprt_pkg::PPRT_ACC_NONE);
    end
  end

  // Read data captured at setup; port reads ignore all routing
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
    end
    else if (setup_phase && !pwrite)
    begin
      case (dec.kind)
        pprt_pkg::PPRT_ACC_SEL:    prdata <= {26'h0000000, sel_reg[dec.idx]};
        pprt_pkg::PPRT_ACC_PORT:   prdata <= pprt_port_word(digital_in, dec.idx[1:0]);
        pprt_pkg::PPRT_ACC_ANALOG: prdata <= pprt_port_word(analog_sel_reg, dec.idx[1:0]);
        default:                   prdata <= 32'h00000000;
      endcase
    end
    else if (!psel)
    begin
      prdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ==== tb/pprt_properties.sv ====
// Checker for the pin router's bus handshake, reset and routing outputs.
// Assumes it is bound to pprt_router and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pprt_properties (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire pprt_pkg::pprt_pins_t   pins_in,
  input wire pprt_pkg::pprt_periph_t periph_in
);
  logic setup;
  logic bad;
  assign setup = psel && !penable && !pready;
  // Holes between the select block and the port block are unmapped too
  assign bad = paddr[1:0] != 2'h0 || (paddr > 12'h0a0 && paddr < 12'h100) || paddr > 12'h11c;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_ready_after_setup;
    setup |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready too long");
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("stray ready");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("stray error");
  property p_err_once;
    pslverr |=> !pslverr;
  endproperty
  a_err_once: assert property (p_err_once) else $error("error too long");
  property p_err_bad;
    setup && bad |=> pslverr;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("missing error");
  property p_ok_good;
    setup && !bad |=> !pslverr;
  endproperty
  a_ok_good: assert property (p_ok_good) else $error("false error");
  property p_rdata_idle;
    !psel && !$past(psel) |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data while idle");
  property p_reset_out;
    disable iff (1'b0) rst |=> periph_in == '0 && !pready;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not reset");
  property p_periph_steady;
    (!rst && !psel && $stable(pins_in))[*8] |-> $stable(periph_in);
  endproperty
  a_periph_steady: assert property (p_periph_steady) else $error("route moved");
  c_write: cover property (setup && pwrite ##1 pready);
  c_error: cover property (pready && pslverr);
  c_route: cover property (!$stable(periph_in));
endmodule
bind pprt_router pprt_properties u_props (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pins_in(pins_in), .periph_in(periph_in)
);
`default_nettype wire

// ==== tb/pprt_pin_model.sv ====
// Model of the device pins feeding the router.
// Assumes the bench sets the wanted levels; pins move off the sampling edge.
`timescale 1ns/10ps
`default_nettype none
module pprt_pin_model (
  input  wire logic                 mclk,
  input  wire pprt_pkg::pprt_pins_t level,
  output var pprt_pkg::pprt_pins_t  pins_in
);
  // Falling edge: pins are not aligned to the router's clock
  always_ff @(negedge mclk)
  begin
    pins_in <= level;
  end
endmodule
`default_nettype wire

// ==== tb/tb_peripheral_input_pin_router.sv ====
// Self-checking bench for the peripheral input pin router.
// Assumes the router, its package and the pin model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "pprt_cfg.svh"
module tb_peripheral_input_pin_router;
  logic                   mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, seed;
  logic [24:0]            an;
  pprt_pkg::pprt_pins_t   level, pins_in;
  pprt_pkg::pprt_periph_t periph_in;
  logic [63:0]            rq[$], pq[$];
  logic [5:0]             codes[6] = '{6'h05, 6'h0b, 6'h13, 6'h23, 6'h3f, 6'h0f};
  int                     n_fail, total_checks;
  event                   pev;
  pprt_router uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .periph_in(periph_in));
  pprt_pin_model u_pins (.mclk(mclk), .level(level), .pins_in(pins_in));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic route_of(input int i, input logic [5:0] c);
    logic [2:0]  ok;
    logic [24:0] eff;
    logic [7:0]  b;
    ok = i < 2 ? 3'h3 : (i inside {2, 4, 6, 8, 11, 12, 13, 18, 22, 23, 29}) ? 3'h5 : 3'h6;
    eff = level & ~an;
    if (c[5:3] > 3'h2 || !ok[c[5:3]])
      return 1'b0;
    b = eff[24 - 8 * c[5:3] -: 8];
    return b[c[2:0]];
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One idle cycle after each transfer keeps drivers single-assigned
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50)
      n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(64'(e));
    apb(1'b0, a, 32'h0);
  endtask
  task automatic route(input logic [5:0] c);
    pprt_pkg::pprt_periph_t e;
    for (int i = 0; i < 41; i++)
      apb(1'b1, 12'(4 * i), {26'h0, c});
    repeat (10) @(posedge mclk);
    for (int i = 0; i < 41; i++)
      e[i] = route_of(i, c);
    pq.push_back(64'(e));
    -> pev;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge mclk)
    if (pready === 1'b1 && pwrite === 1'b0)
      check({31'h0, pslverr, prdata}, rq.size() ? rq.pop_front() : 64'hx);
  always @(pev)
    check(64'(periph_in), pq.pop_front());
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #80000;
    n_fail++;
    give_verdict();
  end
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {level, an, n_fail, total_checks, seed} = {50'h0, 64'h0, 32'h510b};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(12'h000, {27'h0, `PPRT_RST_EXT_INT});
    rd(12'h004, {27'h0, `PPRT_RST_TMR0_CLK});
    rd(12'h008, {27'h0, `PPRT_RST_TMR1_CLK});
    rd(12'h110, 33'h0);
    rd(12'h200, 33'h100000000);
    rd(12'h002, 33'h100000000);
    apb(1'b1, 12'h00c, 32'hffffffc9);
    rd(12'h00c, 33'h09);
    rd(12'h0a0, {27'h0, `PPRT_RST_MEAS2_WIN});
    rd(12'h0a4, 33'h100000000);
    $display("Test registers done");
    for (int t = 0; t < 6; t++)
    begin
      seed = xs(seed);
      level <= seed[24:0];
      route(codes[t]);
    end
    $display("Test routing done");
    apb(1'b1, 12'h100, 32'hffffffff);
    for (int g = 0; g < 3; g++)
      rd(12'(12'h100 + 4 * g), {25'h0, level[24 - 8 * g -: 8]});
    rd(12'h10c, {29'h0, level[0], 3'h0});
    $display("Test port reads done");
    level <= 25'h1fe0000;
    apb(1'b1, 12'h110, 32'h0ff);
    an = 25'h1fe0000;
    route(6'h05);
    rd(12'h110, 33'h0ff);
    rd(12'h100, 33'h0);
    apb(1'b1, 12'h110, 32'h0);
    an = 25'h0;
    route(6'h05);
    apb(1'b1, 12'h114, 32'hffffffa5);
    apb(1'b1, 12'h11c, 32'hffffffff);
    rd(12'h114, 33'h0a5);
    rd(12'h11c, 33'h008);
    $display("Test analog select done");
    if (rq.size() || pq.size())
      n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
